// ===== rtl/mlp_pkg.sv
/*
  Shared constants for the matrix LED PWM refresh and diagnostics block:
  matrix size, timing counts derived from the 40 ns system clock, data
  thresholds, mode codes and memory layout.
  Assumes mclk runs at 25 MHz and stands for the oscillator-derived timebase.
*/
`default_nettype none

package mlp_pkg;

  localparam int LINES = 6;
  localparam int SINKS = 18;
  localparam int DOTS  = 108;

  // timebase
  localparam int CLK_PS       = 40000;
  localparam int PWM_FAST_PS  = 8000000;   // active sink time at 125 kHz
  localparam int PWM_SLOW_PS  = 16000000;  // active sink time at 62.5 kHz
  localparam int PHASE_PS     = 125000;
  localparam int DLY_FAST_PS  = 31250;
  localparam int DLY_SLOW_PS  = 62500;
  localparam int BLANK_PS     = 1000000;
  localparam int PWM_FAST_CYC = PWM_FAST_PS / CLK_PS;
  localparam int PWM_SLOW_CYC = PWM_SLOW_PS / CLK_PS;
  localparam int PHASE_CYC    = (PHASE_PS + CLK_PS - 1) / CLK_PS;
  localparam int DLY_FAST_CYC = (DLY_FAST_PS + CLK_PS - 1) / CLK_PS;
  localparam int DLY_SLOW_CYC = (DLY_SLOW_PS + CLK_PS - 1) / CLK_PS;
  localparam int BLANK_CYC    = (BLANK_PS + CLK_PS - 1) / CLK_PS;
  localparam int DIAG_SAMPLE_CYC = 12;

  // diagnostics
  localparam logic [7:0]  OPEN_MIN_8   = 8'h19;    // 25
  localparam logic [15:0] OPEN_MIN_16  = 16'h1900; // 6400
  localparam int          DETECT_RUNS  = 4;
  localparam logic [1:0]  LAST_RUN     = 2'(DETECT_RUNS - 1);
  localparam logic [7:0]  CLEAR_CODE   = 8'h0f;

  // configuration codes
  localparam logic [1:0] MODE_INSTANT = 2'h0;
  localparam logic [1:0] MODE_FRAME8  = 2'h1;
  localparam logic [1:0] MODE_FRAME16 = 2'h2;
  localparam logic [1:0] GRP_NONE     = 2'h0;
  localparam logic [1:0] GRP_ONE      = 2'h1;
  localparam logic [1:0] GRP_TWO      = 2'h2;
  localparam logic       FREQ_125K    = 1'b0;
  localparam logic       CURVE_EXP    = 1'b1;

  // memory layout: {bank, word}; 16-bit duties live above the 8-bit ones
  localparam int         MEM_AW      = 9;
  localparam logic [7:0] ADDR16_BASE = 8'h80;

  typedef logic [9:0] mlp_pos_t;

endpackage

`default_nettype wire

// ===== rtl/mlp_dot_mem.sv
/*
  Two-port dot data memory: one host write port, one display read port,
  both usable in the same cycle. Read data comes out of a register.
  Assumes both ports run on mclk; a read of the word being written returns
  the old word.
*/
`timescale 1ns/1ps
`default_nettype none

module mlp_dot_mem
  import mlp_pkg::*;
(
  input  wire logic              mclk,
  input  wire logic              wr_en,
  input  wire logic [MEM_AW-1:0] wr_addr,
  input  wire logic [15:0]       wr_data,
  input  wire logic [MEM_AW-1:0] rd_addr,
  output logic      [15:0]       rd_data
);

  logic [15:0] mem [2**MEM_AW];

  always_ff @(posedge mclk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
    rd_data <= mem[rd_addr];
  end

endmodule // mlp_dot_mem

`default_nettype wire

// ===== rtl/mlp_pwm_core.sv
/*
  Per-dot PWM generator for a 6 x 18 scanned LED matrix: scan sequencing,
  duty scaling and curves, refresh modes, open/short filtering and flags.
  Assumes configuration inputs are quasi-static from mclk logic; frame_sync
  and the sink comparator bits come from pins and are synchronised here.
*/
`timescale 1ns/1ps
`default_nettype none

module mlp_pwm_core
  import mlp_pkg::*;
(
  input  wire logic              mclk,
  input  wire logic              resetn,
  input  wire logic              host_addr_load,
  input  wire logic [7:0]        host_addr,
  input  wire logic              host_wr,
  input  wire logic [15:0]       host_wr_data,
  input  wire logic              frame_sync,
  input  wire logic [1:0]        refresh_mode_select,
  input  wire logic              pwm_freq_select,
  input  wire logic              phase_stagger_en,
  input  wire logic              sink_turn_on_delay_en,
  input  wire logic              dimming_curve_select,
  input  wire logic [7:0]        global_duty,
  input  wire logic [7:0]        group_duty_one,
  input  wire logic [7:0]        group_duty_two,
  input  wire logic [7:0]        group_duty_three,
  input  wire logic [2*DOTS-1:0] dot_group_select,
  input  wire logic [DOTS-1:0]   dot_enable_bits,
  input  wire logic              open_channel_cutoff_en,
  input  wire logic              short_line_deghost_cutoff_en,
  input  wire logic              open_clear_wr,
  input  wire logic [7:0]        open_flag_clear,
  input  wire logic              short_clear_wr,
  input  wire logic [7:0]        short_flag_clear,
  input  wire logic [SINKS-1:0]  sink_below_open,
  input  wire logic [SINKS-1:0]  sink_above_short,
  output logic      [LINES-1:0]  scan_line_on,
  output logic      [SINKS-1:0]  current_sink_on,
  output logic      [LINES-1:0]  upside_deghost_on,
  output logic                   any_open_fault,
  output logic                   any_short_fault,
  output logic      [DOTS-1:0]   dot_open_flags,
  output logic      [DOTS-1:0]   dot_short_flags
);

  //////////////////////////////////////////////////////////////////////////////
  // timing derived from configuration

  logic [8:0] pwm_cyc;
  logic [1:0] dly_cyc;
  mlp_pos_t   line_len;

  always_comb begin
    pwm_cyc  = (pwm_freq_select == FREQ_125K) ? 9'(PWM_FAST_CYC) : 9'(PWM_SLOW_CYC);
    dly_cyc  = 2'h0;
    if (sink_turn_on_delay_en) begin
      dly_cyc = (pwm_freq_select == FREQ_125K) ? 2'(DLY_FAST_CYC) : 2'(DLY_SLOW_CYC);
    end
    // mclk stands in for the oscillator timebase, so every count is in mclk cycles
    line_len = mlp_pos_t'(BLANK_CYC) + mlp_pos_t'(pwm_cyc)
             + (phase_stagger_en ? mlp_pos_t'(2 * PHASE_CYC) : 10'h000);
  end

  //////////////////////////////////////////////////////////////////////////////
  // scan sequencer: blank first, then the active part of each line

  mlp_pos_t   line_pos, next_line_pos, rel;
  logic [2:0] line_idx, next_line_idx;
  logic [6:0] line_base;
  logic       in_blank, sub_start, sub_end;

  always_comb begin
    next_line_pos = line_pos + 10'h001;
    next_line_idx = line_idx;
    // >= keeps the counter sane if the frequency is changed mid-line
    if (line_pos >= line_len - 10'h001) begin
      next_line_pos = 10'h000;
      next_line_idx = (line_idx == 3'(LINES - 1)) ? 3'h0 : line_idx + 3'h1;
    end
    line_base = 7'(line_idx * SINKS);
    in_blank  = line_pos < mlp_pos_t'(BLANK_CYC);
    rel       = line_pos - mlp_pos_t'(BLANK_CYC);
    sub_start = (line_idx == 3'h0) && (line_pos == 10'h000);
    sub_end   = (line_idx == 3'(LINES - 1)) && (line_pos >= line_len - 10'h001);
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      line_pos <= 10'h000;
      line_idx <= 3'h0;
    end else begin
      line_pos <= next_line_pos;
      line_idx <= next_line_idx;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // host write pointer, bank swap on frame sync

  logic       fs_meta, fs_sync, fs_last, sync_pend, next_sync_pend;
  logic       wr_bank, next_wr_bank, disp_bank, instant, mode16, apply;
  logic [7:0] wr_ptr, next_wr_ptr, wr_word;

  always_comb begin
    instant = refresh_mode_select == MODE_INSTANT;
    mode16  = refresh_mode_select == MODE_FRAME16;
    // swap on the last cycle of a sub-period: the fetch at line 0 pos 0 already reads the new bank
    apply   = sync_pend && sub_end && !instant;
    next_sync_pend = instant ? 1'b0 : ((sync_pend && !apply) || (fs_sync && !fs_last));
    next_wr_bank   = wr_bank ^ apply;
    // instant mode shows the bank being written, so single dots update alone
    disp_bank = instant ? wr_bank : !wr_bank;
    wr_word   = host_addr_load ? host_addr : wr_ptr;
    next_wr_ptr = wr_word + {7'h00, host_wr};
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      fs_meta   <= 1'b0;
      fs_sync   <= 1'b0;
      fs_last   <= 1'b0;
      sync_pend <= 1'b0;
      wr_bank   <= 1'b0;
      wr_ptr    <= 8'h00;
    end else begin
      fs_meta   <= frame_sync;
      fs_sync   <= fs_meta;
      fs_last   <= fs_sync;
      sync_pend <= next_sync_pend;
      wr_bank   <= next_wr_bank;
      wr_ptr    <= next_wr_ptr;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // duty fetch during blank: read dot k at pos k, scale it at pos k+1

  logic [MEM_AW-1:0] rd_addr;
  logic [15:0]       rd_data, raw16, gam;
  logic [6:0]        rd_dot, cap_dot;
  logic [4:0]        cap_s;
  logic              cap_en, cap_qual;
  logic [7:0]        grp;
  logic [31:0]       sq;
  logic [39:0]       scaled;
  logic [24:0]       cnt_prod;
  logic [8:0]        duty [SINKS];
  logic [8:0]        next_duty [SINKS];
  logic [SINKS-1:0]  qual, next_qual;

  mlp_dot_mem mlp_dot_mem_inst (
    .mclk    (mclk),
    .wr_en   (host_wr),
    .wr_addr ({wr_bank, wr_word}),
    .wr_data (host_wr_data),
    .rd_addr (rd_addr),
    .rd_data (rd_data)
  );

  always_comb begin
    rd_dot  = line_base + 7'(line_pos);
    rd_addr = {disp_bank, mode16 ? ADDR16_BASE + {1'b0, rd_dot} : {1'b0, rd_dot}};
    cap_en  = (line_pos >= 10'h001) && (line_pos <= mlp_pos_t'(SINKS));
    cap_s   = 5'(line_pos - 10'h001);
    cap_dot = line_base + {2'h0, cap_s};
    raw16   = mode16 ? rd_data : {rd_data[7:0], rd_data[7:0]};
    sq      = raw16 * raw16;
    gam     = (dimming_curve_select == CURVE_EXP) ? sq[31:16] : raw16;
    case (dot_group_select[2*cap_dot +: 2])
      GRP_NONE: grp = 8'hff;
      GRP_ONE:  grp = group_duty_one;
      GRP_TWO:  grp = group_duty_two;
      default:  grp = group_duty_three;
    endcase
    scaled   = gam * grp * global_duty;
    cnt_prod = scaled[31:16] * pwm_cyc;
    cap_qual = mode16 ? (rd_data >= OPEN_MIN_16) : (rd_data[7:0] >= OPEN_MIN_8);
    next_duty = duty;
    next_qual = qual;
    if (cap_en) begin
      next_duty[cap_s] = cnt_prod[24:16];
      next_qual[cap_s] = cap_qual;
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      duty <= '{default: 9'h000};
      qual <= '0;
    end else begin
      duty <= next_duty;
      qual <= next_qual;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // sink, scan and de-ghost outputs

  logic [SINKS-1:0] next_sink_on;
  logic [LINES-1:0] next_scan, next_deghost;

  always_comb begin
    logic [6:0] d;
    mlp_pos_t   offs;
    d    = 7'h00;
    offs = 10'h000;
    for (int s = 0; s < SINKS; s++) begin
      d    = line_base + 7'(s);
      offs = {8'h00, dly_cyc};
      if (phase_stagger_en) begin
        offs = offs + mlp_pos_t'((s % 3) * PHASE_CYC);
      end
      next_sink_on[s] = !in_blank && (rel >= offs) && ((rel - offs) < {1'b0, duty[s]})
                      && dot_enable_bits[d]
                      && !(open_channel_cutoff_en && dot_open_flags[d]);
    end
    for (int l = 0; l < LINES; l++) begin
      next_scan[l]    = !in_blank && (line_idx == 3'(l));
      next_deghost[l] = in_blank && (line_idx == 3'(l))
                      && !(short_line_deghost_cutoff_en
                           && (|dot_short_flags[l*SINKS +: SINKS]));
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      current_sink_on   <= '0;
      scan_line_on      <= '0;
      upside_deghost_on <= '0;
    end else begin
      current_sink_on   <= next_sink_on;
      scan_line_on      <= next_scan;
      upside_deghost_on <= next_deghost;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // open and short filters; a detection in the clear cycle survives it

  logic [SINKS-1:0] open_meta, open_samp, short_meta, short_samp;
  logic [1:0]       open_run [DOTS];
  logic [1:0]       short_run [DOTS];
  logic [1:0]       next_open_run [DOTS];
  logic [1:0]       next_short_run [DOTS];
  logic [DOTS-1:0]  next_open_flags, next_short_flags;
  logic             next_any_open, next_any_short, diag_now;

  always_comb begin
    logic [6:0] d;
    logic       live;
    d    = 7'h00;
    live = 1'b0;
    diag_now = !in_blank && (rel == mlp_pos_t'(DIAG_SAMPLE_CYC));
    next_open_run    = open_run;
    next_short_run   = short_run;
    next_open_flags  = dot_open_flags;
    next_short_flags = dot_short_flags;
    next_any_open    = any_open_fault;
    next_any_short   = any_short_fault;
    if (open_clear_wr && (open_flag_clear == CLEAR_CODE)) begin
      next_open_flags = '0;
      next_any_open   = 1'b0;
    end
    if (short_clear_wr && (short_flag_clear == CLEAR_CODE)) begin
      next_short_flags = '0;
      next_any_short   = 1'b0;
    end
    if (diag_now) begin
      for (int s = 0; s < SINKS; s++) begin
        d    = line_base + 7'(s);
        live = qual[s] && dot_enable_bits[d];
        if (live && open_samp[s]) begin
          if (open_run[d] == LAST_RUN) begin
            next_open_flags[d] = 1'b1;
            next_any_open      = 1'b1;
          end else begin
            next_open_run[d] = open_run[d] + 2'h1;
          end
        end else begin
          next_open_run[d] = 2'h0;
        end
        if (live && short_samp[s]) begin
          if (short_run[d] == LAST_RUN) begin
            next_short_flags[d] = 1'b1;
            next_any_short      = 1'b1;
          end else begin
            next_short_run[d] = short_run[d] + 2'h1;
          end
        end else begin
          next_short_run[d] = 2'h0;
        end
      end
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      open_meta       <= '0;
      open_samp       <= '0;
      short_meta      <= '0;
      short_samp      <= '0;
      open_run        <= '{default: 2'h0};
      short_run       <= '{default: 2'h0};
      dot_open_flags  <= '0;
      dot_short_flags <= '0;
      any_open_fault  <= 1'b0;
      any_short_fault <= 1'b0;
    end else begin
      open_meta       <= sink_below_open;
      open_samp       <= open_meta;
      short_meta      <= sink_above_short;
      short_samp      <= short_meta;
      open_run        <= next_open_run;
      short_run       <= next_short_run;
      dot_open_flags  <= next_open_flags;
      dot_short_flags <= next_short_flags;
      any_open_fault  <= next_any_open;
      any_short_fault <= next_any_short;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // checks

  fast_line_a: assert property (@(posedge mclk) disable iff (!resetn)
    (line_pos == mlp_pos_t'(BLANK_CYC) && pwm_freq_select == FREQ_125K && !phase_stagger_en)
    |-> ##200 (line_pos == 10'h000))
    else $error("active period at 125 kHz is not 200 cycles");

  slow_line_a: assert property (@(posedge mclk) disable iff (!resetn)
    (line_pos == mlp_pos_t'(BLANK_CYC) && pwm_freq_select != FREQ_125K && !phase_stagger_en)
    |-> ##[400:400] (line_pos == 10'h000))
    else $error("active period at 62.5 kHz is not 400 cycles");

  sink_delay_a: assert property (@(posedge mclk) disable iff (!resetn)
    (sink_turn_on_delay_en && line_pos == mlp_pos_t'(BLANK_CYC))
    |=> ((|scan_line_on) && current_sink_on == '0))
    else $error("sink turned on together with its scan line");

  phase_three_a: assert property (@(posedge mclk) disable iff (!resetn)
    (phase_stagger_en && line_pos == mlp_pos_t'(BLANK_CYC + 2 * PHASE_CYC - 1))
    |=> !current_sink_on[2])
    else $error("third phase sink turned on early");

  open_summary_a: assert property (@(posedge mclk) disable iff (!resetn)
    $rose(dot_open_flags[0]) |-> any_open_fault)
    else $error("open flag set without summary bit");

  open_clear_a: assert property (@(posedge mclk) disable iff (!resetn)
    (open_clear_wr && open_flag_clear == CLEAR_CODE && !diag_now)
    |=> (dot_open_flags == '0 && !any_open_fault))
    else $error("open indicators not cleared");

  short_clear_a: assert property (@(posedge mclk) disable iff (!resetn)
    (short_clear_wr && short_flag_clear == CLEAR_CODE && !diag_now)
    |=> (dot_short_flags == '0 && !any_short_fault))
    else $error("short indicators not cleared");

  open_cutoff_a: assert property (@(posedge mclk) disable iff (!resetn)
    (open_channel_cutoff_en && dot_open_flags[0] && line_idx == 3'h0)
    |=> !current_sink_on[0])
    else $error("open-flagged sink driven on its line");

  deghost_cut_a: assert property (@(posedge mclk) disable iff (!resetn)
    (short_line_deghost_cutoff_en && dot_short_flags[0]) |=> !upside_deghost_on[0])
    else $error("de-ghosting on a line with a short");

  bank_swap_a: assert property (@(posedge mclk) disable iff (!resetn)
    $changed(wr_bank) |-> (sub_start && !instant))
    else $error("frame bank swapped outside a sub-period start");

endmodule // mlp_pwm_core

`default_nettype wire

// ===== dv/mlp_host_model.sv
/*
  host-side partner: frame sync pulses and the sink comparator pins.
  assumes the bench raises sync_req for one mclk cycle per frame.
*/
`timescale 1ns/1ps
`default_nettype none

module mlp_host_model
  import mlp_pkg::*;
#(
  parameter int SYNC_HIGH = 6
)
(
  input  wire logic             mclk,
  input  wire logic             sync_req,
  input  wire logic             open_lvl,
  input  wire logic             short_lvl,
  output logic                  frame_sync,
  output logic      [SINKS-1:0] sink_below_open,
  output logic      [SINKS-1:0] sink_above_short
);
  int unsigned hold = 0;

  // held well past the two-flop synchroniser so the edge is never missed
  always_ff @(posedge mclk) begin
    if (sync_req) hold <= SYNC_HIGH;
    else if (hold != 0) hold <= hold - 1;
  end

  assign frame_sync       = (hold != 0);
  assign sink_below_open  = {{(SINKS-1){1'b0}}, open_lvl};
  assign sink_above_short = {{(SINKS-1){1'b0}}, short_lvl};
endmodule // mlp_host_model

`default_nettype wire

// ===== dv/test_mlp_pwm_core.sv
/*
  bench for mlp_pwm_core: page writes, scan measurement, refresh modes, diagnostics.
  assumes mlp_host_model supplies frame sync and comparator pins.
*/
`timescale 1ns/1ps
`default_nettype none

module test_mlp_pwm_core
  import mlp_pkg::*;
;

  logic              mclk = 1'b0;
  logic              resetn = 1'b0;
  logic              host_addr_load, host_wr, frame_sync, sync_req, open_lvl, short_lvl;
  logic [7:0]        host_addr, bs;
  logic [15:0]       host_wr_data;
  logic [1:0]        refresh_mode_select;
  logic              pwm_freq_select, phase_stagger_en, sink_turn_on_delay_en;
  logic              dimming_curve_select, open_channel_cutoff_en, short_line_deghost_cutoff_en;
  logic [7:0]        global_duty, group_duty_one, group_duty_two, group_duty_three;
  logic [2*DOTS-1:0] dot_group_select;
  logic [DOTS-1:0]   dot_enable_bits, mask, dot_open_flags, dot_short_flags;
  logic              open_clear_wr, short_clear_wr, any_open_fault, any_short_fault;
  logic [7:0]        open_flag_clear, short_flag_clear;
  logic [SINKS-1:0]  sink_below_open, sink_above_short, current_sink_on;
  logic [LINES-1:0]  scan_line_on, upside_deghost_on;
  int                bad_count = 0;
  int                total_checks = 0;
  int                m_cnt, m_first, m_lon, m_dg, f0;

  always #20 mclk = ~mclk;

  mlp_pwm_core mlp_pwm_core_inst (
    .mclk(mclk), .resetn(resetn), .host_addr_load(host_addr_load), .host_addr(host_addr),
    .host_wr(host_wr), .host_wr_data(host_wr_data), .frame_sync(frame_sync),
    .refresh_mode_select(refresh_mode_select), .pwm_freq_select(pwm_freq_select),
    .phase_stagger_en(phase_stagger_en), .sink_turn_on_delay_en(sink_turn_on_delay_en),
    .dimming_curve_select(dimming_curve_select), .global_duty(global_duty),
    .group_duty_one(group_duty_one), .group_duty_two(group_duty_two),
    .group_duty_three(group_duty_three), .dot_group_select(dot_group_select),
    .dot_enable_bits(dot_enable_bits), .open_channel_cutoff_en(open_channel_cutoff_en),
    .short_line_deghost_cutoff_en(short_line_deghost_cutoff_en),
    .open_clear_wr(open_clear_wr), .open_flag_clear(open_flag_clear),
    .short_clear_wr(short_clear_wr), .short_flag_clear(short_flag_clear),
    .sink_below_open(sink_below_open), .sink_above_short(sink_above_short),
    .scan_line_on(scan_line_on), .current_sink_on(current_sink_on),
    .upside_deghost_on(upside_deghost_on), .any_open_fault(any_open_fault),
    .any_short_fault(any_short_fault), .dot_open_flags(dot_open_flags),
    .dot_short_flags(dot_short_flags));

  mlp_host_model mlp_host_model_inst (
    .mclk(mclk), .sync_req(sync_req), .open_lvl(open_lvl), .short_lvl(short_lvl),
    .frame_sync(frame_sync), .sink_below_open(sink_below_open),
    .sink_above_short(sink_above_short));

  //////////////////////////////////////////////////////////////////////////////
  task automatic finish_test();
    if (bad_count == 0 && total_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic chk(input string name, input logic [127:0] seen, input logic [127:0] exp);
    total_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("ERROR %s expected %0h seen %0h", name, exp, seen);
    end
  endtask

  task automatic step();
    @(posedge mclk);
    #1;
  endtask

  // line-length settings move only in blank, except the stagger switch-off, so no line changes length mid-count
  task automatic idle();
    while (scan_line_on !== '0) step();
  endtask

  // auto-increment after one pointer load
  task automatic wr_words(input logic [7:0] base, input int n, input logic [15:0] v);
    host_addr_load = 1'b1;
    host_addr = base;
    host_wr = 1'b1;
    host_wr_data = v;
    repeat (n) begin
      step();
      host_addr_load = 1'b0;
    end
    host_wr = 1'b0;
    step();
  endtask

  // on-cycles of one sink over a whole sub-period starting at line 0
  task automatic measure(input int s);
    int k;
    int len;
    len = 6 * (25 + (pwm_freq_select ? 400 : 200) + (phase_stagger_en ? 8 : 0));
    k = 0;
    while (scan_line_on[0] === 1'b1 && k < 9000) begin step(); k++; end
    while (scan_line_on[0] !== 1'b1 && k < 9000) begin step(); k++; end
    m_cnt = 0;
    m_first = -1;
    m_lon = 0;
    m_dg = 0;
    for (k = 0; k < len; k++) begin
      if (current_sink_on[s] === 1'b1) begin
        if (m_first < 0) m_first = k;
        m_cnt++;
      end
      if (scan_line_on[0] === 1'b1) m_lon++;
      if (upside_deghost_on[0] === 1'b1) m_dg++;
      step();
    end
  endtask

  task automatic sync();
    sync_req = 1'b1;
    step();
    sync_req = 1'b0;
    measure(0);
  endtask

  task automatic clr(input bit sh, input logic [7:0] code);
    open_flag_clear = code;
    short_flag_clear = code;
    open_clear_wr = !sh;
    short_clear_wr = sh;
    step();
    {open_clear_wr, short_clear_wr} = '0;
    step();
  endtask

  // sink on-cycles in six lines for a 16-bit duty word
  function automatic int e6(input logic [15:0] d, input int g, input int gl, input bit ex);
    longint c;
    c = ex ? ((longint'(d) * d) >> 16) : longint'(d);
    c = (c * g * gl) >> 16;
    return 6 * int'((c * (pwm_freq_select ? 400 : 200)) >> 16);
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (120000) @(posedge mclk);
    bad_count++;
    finish_test();
  end

  initial begin
    {host_addr_load, host_wr, sync_req, open_lvl, short_lvl, open_clear_wr} = '0;
    {short_clear_wr, host_addr, host_wr_data, refresh_mode_select, pwm_freq_select} = '0;
    {phase_stagger_en, sink_turn_on_delay_en, dimming_curve_select} = '0;
    {open_channel_cutoff_en, short_line_deghost_cutoff_en, dot_group_select} = '0;
    {open_flag_clear, short_flag_clear} = '0;
    {global_duty, group_duty_one, group_duty_two, group_duty_three} = '1;
    dot_enable_bits = '1;
    repeat (4) @(posedge mclk);
    #1 resetn = 1'b1;
    wr_words(8'h00, DOTS, 16'h00ff);
    measure(0);
    chk("full duty", m_cnt, e6(16'hffff, 255, 255, 0));
    wr_words(8'h00, DOTS, 16'h0080);
    for (int fr = 0; fr < 2; fr++) begin
      idle();
      pwm_freq_select = fr[0];
      measure(0);
      f0 = m_first;
      chk("half duty", m_cnt, e6(16'h8080, 255, 255, 0));
      chk("line on", m_lon, fr ? 400 : 200);
      sink_turn_on_delay_en = 1'b1;
      measure(0);
      chk("sink delay", m_first - f0, fr + 1);
      sink_turn_on_delay_en = 1'b0;
    end
    idle();
    pwm_freq_select = 1'b0;
    dimming_curve_select = 1'b1;
    measure(0);
    chk("exp curve", m_cnt, e6(16'h8080, 255, 255, 1));
    dimming_curve_select = 1'b0;
    {group_duty_one, group_duty_two, group_duty_three} = {8'h80, 8'h40, 8'h20};
    for (int c = 1; c < 4; c++) begin
      dot_group_select = {DOTS{c[1:0]}};
      measure(0);
      chk("group", m_cnt, e6(16'h8080, 256 >> c, 255, 0));
    end
    dot_group_select = '0;
    global_duty = 8'h80;
    measure(0);
    chk("global", m_cnt, e6(16'h8080, 255, 128, 0));
    global_duty = 8'hff;
    dot_enable_bits = '0;
    measure(0);
    chk("dots off", m_cnt, 0);
    dot_enable_bits = '1;
    idle();
    phase_stagger_en = 1'b1;
    measure(0);
    f0 = m_first;
    for (int s = 1; s < 3; s++) begin
      measure(s);
      chk("stagger", m_first - f0, 4 * s);
    end
    phase_stagger_en = 1'b0;
    for (int i = 0; i < 2; i++) begin
      refresh_mode_select = i ? MODE_FRAME16 : MODE_FRAME8;
      bs = i ? ADDR16_BASE : 8'h00;
      wr_words(bs, DOTS, i ? 16'hffff : 16'h00ff);
      sync();
      wr_words(bs, DOTS, i ? 16'h8000 : 16'h0080);
      measure(0);
      chk("held old", m_cnt, e6(16'hffff, 255, 255, 0));
      sync();
      measure(0);
      chk("held new", m_cnt, e6(i ? 16'h8000 : 16'h8080, 255, 255, 0));
    end
    // dot 18 sits one step under the detection floor
    refresh_mode_select = MODE_INSTANT;
    wr_words(8'h00, DOTS, 16'h0019);
    wr_words(8'h12, 1, 16'h0018);
    for (int d = 0; d < DOTS; d++) mask[d] = (d % SINKS == 0) && (d != SINKS);
    open_lvl = 1'b1;
    measure(0);
    chk("open early", any_open_fault, 0);
    repeat (3) measure(0);
    chk("open sum", any_open_fault, 1);
    chk("open dots", dot_open_flags, mask);
    open_channel_cutoff_en = 1'b1;
    measure(0);
    chk("cut sink", m_cnt, e6(16'h1818, 255, 255, 0) / 6);
    measure(1);
    chk("kept sink", m_cnt, e6(16'h1919, 255, 255, 0));
    open_channel_cutoff_en = 1'b0;
    open_lvl = 1'b0;
    clr(0, 8'h0e);
    chk("open kept", dot_open_flags, mask);
    clr(0, CLEAR_CODE);
    chk("open clr", {any_open_fault, dot_open_flags}, 0);
    short_lvl = 1'b1;
    measure(0);
    chk("deghost on", m_dg != 0, 1);
    repeat (3) measure(0);
    chk("short dots", {any_short_fault, dot_short_flags}, {1'b1, mask});
    short_line_deghost_cutoff_en = 1'b1;
    measure(0);
    chk("deghost cut", m_dg, 0);
    short_lvl = 1'b0;
    clr(1, CLEAR_CODE);
    chk("short clr", {any_short_fault, dot_short_flags}, 0);
    finish_test();
  end
endmodule // test_mlp_pwm_core

`default_nettype wire
